// [rtl/instr_decode_regs.svh]
// constants for the instruction length and address generation block
// Functional notes
// - op code is always the first, high-order instruction byte
// - op bits 0,1: 00 one halfword, 01/10 two, 11 three halfwords
// - op bits 2,3 give the data type class
// - op bits 4..7 give the operation to perform
// - odd instruction address raises a specification exception
// - 4-bit register address selects one of sixteen general registers
// - one-halfword form takes both register addresses from byte two
// - storage operand addresses are 24 bits wide
// - address is displacement plus base plus index when indexed
// - register 0 as base or index contributes zero
// - address generation never modifies instruction or registers
// - only the low 24 bits of base and index are used
`ifndef INSTR_DECODE_REGS_SVH
`define INSTR_DECODE_REGS_SVH

// ****************************************************************
// field positions inside the 48-bit instruction image
// ****************************************************************
`define OP_HI 47
`define OP_LO 40
`define BYTE2_HI 39
`define R1_LO 36
`define R2_HI 35
`define R2_LO 32
`define B1_HI 31
`define B1_LO 28
`define D1_HI 27
`define D1_LO 16
`define B2_HI 15
`define B2_LO 12
`define D2_HI 11
`define D2_LO 0
// op code sub-fields, bit 0 is the leftmost of the byte
`define OPLEN_HI 7
`define OPLEN_LO 6
`define OPTYPE_HI 5
`define OPTYPE_LO 4
`define OPFN_HI 3
`define OPFN_LO 0
`define ADDR_W 24
`define REG_AW 4
`define ZERO_REG 4'h0
// length codes in op bits 0,1 and the halfword counts they give
`define LEN_RR 2'h0
`define LEN_RX 2'h1
`define LEN_SS 2'h3
`define HW_ONE 2'h1
`define HW_TWO 2'h2
`define HW_THREE 2'h3
// halfword alignment bit of an instruction address
`define ADDR_LSB 0

`endif

// [rtl/instr_decode_pkg.sv]
// types for the instruction length and address generation block
package instr_decode_pkg;

    // instruction length class from op bits 0,1
    typedef enum logic [1:0] {
        LEN_ONE_HALF,
        LEN_TWO_HALF,
        LEN_THREE_HALF
    } len_class_t;

    // storage address generation states
    typedef enum logic [1:0] {
        AG_IDLE,
        AG_FIRST,
        AG_SECOND
    } ag_state_t;

endpackage : instr_decode_pkg

// [rtl/reg_addr_fetch.sv]
// register-file read port with register 0 forced to zero
`timescale 1ns/100ps
`include "instr_decode_regs.svh"
module reg_addr_fetch #(
    parameter int DATA_W = 32
) (
    input wire logic [`REG_AW-1:0] sel,
    input wire logic [DATA_W-1:0] rd_data,
    output logic [DATA_W-1:0] value
);
    // a register narrower than an address cannot serve as a base
    if (DATA_W < `ADDR_W) begin : g_width_bad
        $error("register width below address width");
    end

    // register 0 means no component, its contents are ignored
    assign value = (sel == `ZERO_REG) ? '0 : rd_data;
endmodule : reg_addr_fetch

// [rtl/ea_adder.sv]
// 24-bit effective address adder
`timescale 1ns/100ps
`include "instr_decode_regs.svh"
module ea_adder #(
    parameter int DATA_W = 32
) (
    input wire logic [DATA_W-1:0] base_val,
    input wire logic [DATA_W-1:0] index_val,
    input wire logic [11:0] disp,
    output logic [`ADDR_W-1:0] sum
);
    wire logic [`ADDR_W-1:0] base_lo;
    wire logic [`ADDR_W-1:0] index_lo;
    wire logic [`ADDR_W-1:0] disp_ext;

    // upper register bits play no part in the address
    assign base_lo = base_val[`ADDR_W-1:0];
    assign index_lo = index_val[`ADDR_W-1:0];
    assign disp_ext = {{(`ADDR_W-12){1'b0}}, disp};
    // width of the sum equals the address, so the carry drops out
    assign sum = base_lo + index_lo + disp_ext;
endmodule : ea_adder

// [rtl/instr_length_and_address_gen.sv]
// instruction decode: length, type, register fields, storage addresses
`timescale 1ns/100ps
`include "instr_decode_regs.svh"
module instr_length_and_address_gen #(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic srst,
    // instruction from the fetch path
    input wire logic instr_valid,
    input wire logic [47:0] instr,
    input wire logic [`ADDR_W-1:0] instr_addr,
    // general register file read port (read only)
    output logic [`REG_AW-1:0] gr_rd_sel,
    input wire logic [DATA_W-1:0] gr_rd_data,
    // decode results
    output logic busy,
    output logic dec_valid,
    output logic [7:0] op_code,
    output logic [1:0] len_halfwords,
    output logic [1:0] data_type,
    output logic [3:0] operation,
    output logic [`REG_AW-1:0] r1_addr,
    output logic [`REG_AW-1:0] r2_addr,
    output logic op1_in_storage,
    output logic op2_in_storage,
    output logic [`ADDR_W-1:0] addr1,
    output logic [`ADDR_W-1:0] addr2,
    output logic spec_exc
);
    // ****************************************************************
    // parameter check
    // ****************************************************************
    // a register narrower than an address cannot serve as a base
    if (DATA_W < `ADDR_W) begin : g_width_bad
        $error("DATA_W must cover a 24-bit address");
    end

    // ****************************************************************
    // op code decode helpers
    // ****************************************************************
    // is_three is used on the offered image and again on the held copy; the others only on the offered image
    function automatic logic is_reg_form(input logic [1:0] bits);
        return (bits == `LEN_RR);
    endfunction : is_reg_form

    function automatic logic is_three(input logic [1:0] bits);
        return (bits == `LEN_SS);
    endfunction : is_three

    // only the 01 form carries an index register field
    function automatic logic is_indexed(input logic [1:0] bits);
        return (bits == `LEN_RX);
    endfunction : is_indexed

    // length class of an op code's two leading bits
    function automatic instr_decode_pkg::len_class_t len_class(
        input logic [1:0] bits
    );
        if (is_reg_form(bits)) begin
            return instr_decode_pkg::LEN_ONE_HALF;
        end else if (is_three(bits)) begin
            return instr_decode_pkg::LEN_THREE_HALF;
        end
        return instr_decode_pkg::LEN_TWO_HALF;
    endfunction : len_class

    // halfword count reported for a length class
    function automatic logic [1:0] halfword_count(
        input instr_decode_pkg::len_class_t cls
    );
        logic [1:0] cnt;
        case (cls)
            instr_decode_pkg::LEN_ONE_HALF: cnt = `HW_ONE;
            instr_decode_pkg::LEN_THREE_HALF: cnt = `HW_THREE;
            default: cnt = `HW_TWO;
        endcase
        return cnt;
    endfunction : halfword_count

    // ****************************************************************
    // op code decode
    // ****************************************************************
    wire logic [7:0] opc;
    wire logic [1:0] len_bits;
    wire logic odd_addr;
    wire logic [1:0] len_num;
    wire logic indexed;
    wire logic reg_form;
    instr_decode_pkg::len_class_t len_cls;

    // op code sits in the leading byte whatever the length
    assign opc = instr[`OP_HI:`OP_LO];
    assign len_bits = opc[`OPLEN_HI:`OPLEN_LO];
    assign len_cls = len_class(len_bits);
    assign len_num = halfword_count(len_cls);
    // register form: both operands in registers, no address work
    assign reg_form = is_reg_form(len_bits);
    // 01 form carries an index field in the second register nibble
    assign indexed = is_indexed(len_bits);
    // halfword boundary violated
    assign odd_addr = instr_addr[`ADDR_LSB];

    // ****************************************************************
    // address generation sequencer
    // ****************************************************************
    // one register read per cycle: index, then base per operand
    instr_decode_pkg::ag_state_t st_reg;
    instr_decode_pkg::ag_state_t st_next;
    logic [47:0] ir_reg; // private copy, never written back
    logic [1:0] step_reg;
    logic [DATA_W-1:0] idx_reg;
    wire logic [DATA_W-1:0] reg_val;
    wire logic [`ADDR_W-1:0] ea_sum;
    wire logic [7:0] ir_opc;
    wire logic [1:0] ir_len;
    wire logic [`REG_AW-1:0] ir_b1;
    wire logic [`REG_AW-1:0] ir_b2;
    wire logic [11:0] disp_now;
    wire logic ir_three;

    // the held image steers the walk once the offer has gone
    assign ir_opc = ir_reg[`OP_HI:`OP_LO];
    assign ir_len = ir_opc[`OPLEN_HI:`OPLEN_LO];
    assign ir_b1 = ir_reg[`B1_HI:`B1_LO];
    assign ir_b2 = ir_reg[`B2_HI:`B2_LO];
    assign ir_three = is_three(ir_len);
    // displacement of the operand being formed
    assign disp_now = (st_reg == instr_decode_pkg::AG_FIRST) ?
        ir_reg[`D1_HI:`D1_LO] : ir_reg[`D2_HI:`D2_LO];

    reg_addr_fetch #(.DATA_W(DATA_W)) reg_addr_fetch_inst (
        .sel(gr_rd_sel),
        .rd_data(gr_rd_data),
        .value(reg_val)
    );

    ea_adder #(.DATA_W(DATA_W)) ea_adder_inst (
        .base_val(reg_val),
        .index_val(idx_reg),
        .disp(disp_now),
        .sum(ea_sum)
    );

    wire logic last_step;
    assign last_step = (step_reg == 2'h1);

    // next state of the sequencer
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            instr_decode_pkg::AG_IDLE: begin
                if (instr_valid && !odd_addr && !reg_form) begin
                    st_next = instr_decode_pkg::AG_FIRST;
                end
            end
            instr_decode_pkg::AG_FIRST: begin
                if (last_step) begin
                    st_next = ir_three ? instr_decode_pkg::AG_SECOND :
                        instr_decode_pkg::AG_IDLE;
                end
            end
            instr_decode_pkg::AG_SECOND: begin
                if (last_step) begin
                    st_next = instr_decode_pkg::AG_IDLE;
                end
            end
            default: begin
                st_next = instr_decode_pkg::AG_IDLE;
            end
        endcase
    end

    // sequencer state and operand step
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= instr_decode_pkg::AG_IDLE;
            step_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            step_reg <= (st_reg == instr_decode_pkg::AG_IDLE || last_step) ?
                2'h0 : 2'h1;
        end
    end

    // hold the instruction and the fetched index; nothing writes back
    always_ff @(posedge clk) begin
        if (srst) begin
            ir_reg <= '0;
            idx_reg <= '0;
        end else begin
            if (st_reg == instr_decode_pkg::AG_IDLE && instr_valid) begin
                ir_reg <= instr;
            end
            if (st_reg != instr_decode_pkg::AG_IDLE && !last_step) begin
                idx_reg <= reg_val;
            end
        end
    end

    // ****************************************************************
    // register file select
    // ****************************************************************
    wire logic [`REG_AW-1:0] sel_enter;
    wire logic [`REG_AW-1:0] sel_base;
    wire logic [`REG_AW-1:0] sel_next;
    // first read of an operand fetches the index, register 0 for none
    assign sel_enter = indexed ? instr[`R2_HI:`R2_LO] : `ZERO_REG;
    // second read fetches the operand's base
    assign sel_base = (st_reg == instr_decode_pkg::AG_FIRST) ? ir_b1 : ir_b2;
    // select comes from a flop, so it is worked out a cycle ahead;
    // entering the second operand reads register 0 as its index
    assign sel_next = (st_next == instr_decode_pkg::AG_IDLE) ? `ZERO_REG :
        (st_reg == instr_decode_pkg::AG_IDLE) ? sel_enter :
        (st_next != st_reg) ? `ZERO_REG : sel_base;

    always_ff @(posedge clk) begin
        if (srst) begin
            gr_rd_sel <= `ZERO_REG;
        end else begin
            gr_rd_sel <= sel_next;
        end
    end

    // ****************************************************************
    // result registers
    // ****************************************************************
    wire logic accept;
    wire logic finish;
    assign accept = (st_reg == instr_decode_pkg::AG_IDLE) && instr_valid;
    assign finish = (st_reg != instr_decode_pkg::AG_IDLE) && last_step &&
        (st_next == instr_decode_pkg::AG_IDLE);

    // decoded fields latch on accept
    always_ff @(posedge clk) begin
        if (srst) begin
            op_code <= 8'h00;
            len_halfwords <= 2'h0;
            data_type <= 2'h0;
            operation <= 4'h0;
            r1_addr <= `ZERO_REG;
            r2_addr <= `ZERO_REG;
            op1_in_storage <= 1'b0;
            op2_in_storage <= 1'b0;
        end else if (accept) begin
            op_code <= opc;
            len_halfwords <= len_num;
            data_type <= opc[`OPTYPE_HI:`OPTYPE_LO];
            operation <= opc[`OPFN_HI:`OPFN_LO];
            r1_addr <= instr[`BYTE2_HI:`R1_LO];
            r2_addr <= instr[`R2_HI:`R2_LO];
            op1_in_storage <= is_three(len_bits);
            op2_in_storage <= !reg_form;
        end
    end

    // ****************************************************************
    // completion and exception pulses
    // ****************************************************************
    wire logic quick_done;
    wire logic exc_next;
    wire logic done_next;
    wire logic busy_next;
    // odd addresses and register forms finish without a register read
    assign quick_done = accept && (odd_addr || reg_form);
    assign exc_next = accept && odd_addr;
    assign done_next = quick_done || finish;
    assign busy_next = (st_next != instr_decode_pkg::AG_IDLE);

    // pulses last one cycle; busy mirrors the sequencer's next state
    always_ff @(posedge clk) begin
        if (srst) begin
            spec_exc <= 1'b0;
            dec_valid <= 1'b0;
            busy <= 1'b0;
        end else begin
            spec_exc <= exc_next;
            dec_valid <= done_next;
            busy <= busy_next;
        end
    end

    // ****************************************************************
    // storage addresses
    // ****************************************************************
    wire logic first_done;
    wire logic second_done;
    assign first_done = (st_reg == instr_decode_pkg::AG_FIRST) && last_step;
    assign second_done = (st_reg == instr_decode_pkg::AG_SECOND) && last_step;

    // a new offer clears both, so unused operands read as zero
    always_ff @(posedge clk) begin
        if (srst) begin
            addr1 <= '0;
            addr2 <= '0;
        end else begin
            if (accept) begin
                addr1 <= '0;
                addr2 <= '0;
            end
            // two-halfword forms put the storage operand in addr2
            if (first_done && ir_three) begin
                addr1 <= ea_sum;
            end
            if ((first_done && !ir_three) || second_done) begin
                addr2 <= ea_sum;
            end
        end
    end
endmodule : instr_length_and_address_gen

// [sim/instr_decode_props.sv]
// assertion checker for the instruction decode block
`timescale 1ns/100ps
`include "instr_decode_regs.svh"
module instr_decode_props #(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic instr_valid,
    input wire logic [47:0] instr,
    input wire logic [`ADDR_W-1:0] instr_addr,
    input wire logic [`REG_AW-1:0] gr_rd_sel,
    input wire logic [DATA_W-1:0] gr_rd_data,
    input wire logic busy,
    input wire logic dec_valid,
    input wire logic [7:0] op_code,
    input wire logic [1:0] len_halfwords,
    input wire logic [1:0] data_type,
    input wire logic [3:0] operation,
    input wire logic [`REG_AW-1:0] r1_addr,
    input wire logic [`REG_AW-1:0] r2_addr,
    input wire logic op1_in_storage,
    input wire logic op2_in_storage,
    input wire logic [`ADDR_W-1:0] addr1,
    input wire logic [`ADDR_W-1:0] addr2,
    input wire logic spec_exc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // a take is any idle edge with a request; even take of a non-register form starts address work
    wire take = instr_valid && !busy;
    wire take_even = take && !instr_addr[0];
    wire [1:0] lc = op_code[7:6];
    chk_op_latch: assert property (
        take |=> op_code == $past(instr[47:40]))
        else $error("op code not taken from the first byte");
    chk_reg_fields: assert property (
        take |=> {r1_addr, r2_addr} == $past(instr[39:32]))
        else $error("register fields not taken from byte two");
    chk_len_code: assert property (
        dec_valid |-> len_halfwords ==
            (lc == 2'h0 ? 2'h1 : (lc == 2'h3 ? 2'h3 : 2'h2)))
        else $error("length does not follow op bits 0 and 1");
    chk_type_field: assert property (
        dec_valid |-> data_type == op_code[5:4])
        else $error("data type field wrong");
    chk_fn_field: assert property (
        dec_valid |-> operation == op_code[3:0])
        else $error("operation field wrong");
    chk_store_flags: assert property (
        dec_valid |-> op1_in_storage == (lc == 2'h3)
            && op2_in_storage == (lc != 2'h0))
        else $error("operand location flags wrong");
    chk_odd_exc: assert property (
        take && instr_addr[0] |=> dec_valid && spec_exc)
        else $error("odd address gave no exception pulse");
    chk_exc_cause: assert property (
        spec_exc |-> $past(take && instr_addr[0]))
        else $error("exception pulse without an odd address taken");
    chk_rr_fast: assert property (
        take_even && instr[47:46] == 2'h0 |=> dec_valid && !spec_exc)
        else $error("register form not answered next cycle");
    chk_rx_walk: assert property (
        take_even && (instr[47:46] == 2'h1 || instr[47:46] == 2'h2)
            |=> busy ##1 busy ##1 (dec_valid && !busy))
        else $error("two halfword form timing wrong");
    chk_ss_walk: assert property (
        take_even && instr[47:46] == 2'h3
            |=> busy [*4] ##1 (dec_valid && !busy))
        else $error("three halfword form timing wrong");
    chk_rr_noaddr: assert property (
        dec_valid && lc == 2'h0 |-> addr1 == 24'h0 && addr2 == 24'h0)
        else $error("register form left a storage address");
    chk_sel_idle: assert property (
        !busy |-> gr_rd_sel == `ZERO_REG)
        else $error("register select left active while idle");
    chk_sel_order: assert property (
        take_even && instr[47:46] == 2'h1
            |=> gr_rd_sel == $past(instr[35:32])
            ##1 gr_rd_sel == $past(instr[31:28], 2))
        else $error("index then base not selected in turn");
endmodule : instr_decode_props

// [sim/gr_file_model.sv]
// general register file model answering the decoder read port
`timescale 1ns/100ps
module gr_file_model #(
    parameter int DATA_W = 32
) (
    input wire logic [3:0] sel,
    output logic [DATA_W-1:0] rd_data
);
    // sixteen word registers, loaded by the bench, never written here
    logic [DATA_W-1:0] regs [16];
    // combinational read, since the decoder samples in the same cycle
    assign rd_data = regs[sel];
endmodule : gr_file_model

// [sim/tb_instr_length_and_address_gen.sv]
// self-checking bench for the instruction decode block
`timescale 1ns/100ps
`include "instr_decode_regs.svh"
module tb_instr_length_and_address_gen;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic instr_valid = 1'b0;
    logic [47:0] instr = 48'h0;
    logic [23:0] instr_addr = 24'h0;
    logic [3:0] gr_rd_sel;
    logic [31:0] gr_rd_data, r0, r1;
    logic busy, dec_valid, op1_in_storage, op2_in_storage, spec_exc;
    logic [7:0] op_code;
    logic [1:0] len_halfwords, data_type;
    logic [3:0] operation, r1_addr, r2_addr;
    logic [23:0] addr1, addr2;
    logic [31:0] gr [16];
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    integer seed = 32'h0966;
    always #4 clk = ~clk;
    instr_length_and_address_gen instr_length_and_address_gen_inst (
        .clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
        .instr_addr(instr_addr), .gr_rd_sel(gr_rd_sel),
        .gr_rd_data(gr_rd_data), .busy(busy), .dec_valid(dec_valid),
        .op_code(op_code), .len_halfwords(len_halfwords),
        .data_type(data_type), .operation(operation), .r1_addr(r1_addr),
        .r2_addr(r2_addr), .op1_in_storage(op1_in_storage),
        .op2_in_storage(op2_in_storage), .addr1(addr1), .addr2(addr2),
        .spec_exc(spec_exc));
    gr_file_model gr_file_model_inst (.sel(gr_rd_sel), .rd_data(gr_rd_data));
    // ****************************************
    // checking and expectation helpers
    // ****************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    // register 0 stands for zero; only the low 24 bits take part
    function automatic logic [23:0] ea(input logic [3:0] b,
        input logic [3:0] x, input logic [11:0] d);
        logic [23:0] bv, xv;
        bv = (b == 4'h0) ? 24'h0 : gr[b][23:0];
        xv = (x == 4'h0) ? 24'h0 : gr[x][23:0];
        return bv + xv + {12'h0, d};
    endfunction : ea
    task automatic load(input int i, input logic [31:0] v);
        gr[i] = v;
        gr_file_model_inst.regs[i] = v;
    endtask : load
    // offer one instruction, wait for its answer, compare every field, storage addresses only at even addresses
    task automatic issue(input logic [47:0] w, input logic [23:0] a);
        logic [1:0] lc;
        int n;
        lc = w[47:46];
        n = 0;
        instr_valid = 1'b1;
        instr = w;
        instr_addr = a;
        @(negedge clk);
        instr_valid = 1'b0;
        instr = ~w; // released lines no longer show the old value
        instr_addr = ~a;
        while (dec_valid !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        check(n, (lc == 2'h0 || a[0]) ? 0 : (lc == 2'h3 ? 4 : 2));
        check(op_code, w[47:40]);
        check(len_halfwords, lc == 2'h0 ? 1 : (lc == 2'h3 ? 3 : 2));
        check(data_type, w[45:44]);
        check(operation, w[43:40]);
        check({r1_addr, r2_addr}, w[39:32]);
        check({op1_in_storage, op2_in_storage},
            {lc == 2'h3, lc != 2'h0});
        check(spec_exc, a[0]);
        if (!a[0]) begin
            check(addr1, lc == 2'h3 ? ea(w[31:28], 4'h0, w[27:16]) :
                24'h0);
            check(addr2, lc == 2'h0 ? 24'h0 : (lc == 2'h3 ? ea(w[15:12], 4'h0,
                w[11:0]) : ea(w[31:28], lc == 2'h1 ? w[35:32] : 4'h0,
                w[27:16])));
        end
    endtask : issue
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        for (int i = 0; i < 16; i++) begin
            load(i, $random(seed));
        end
        load(0, 32'h12345678); // register 0 must be ignored
        load(15, 32'hFFFFFFFF); // upper byte set, sums carry out
        repeat (6) @(negedge clk);
        srst = 1'b0;
        check({busy, dec_valid, spec_exc, gr_rd_sel, addr1, addr2},
            55'h0);
        // back-to-back corner cases, each offered as the last one ends
        issue(48'h183F00000000, 24'h000000);
        issue(48'h5A1FFFFF0000, 24'h000100);
        issue(48'h5A000ABC0000, 24'h000002);
        issue(48'h947F71230000, 24'hFFFFFE);
        issue(48'hFA00FFFF0ABC, 24'h000004);
        issue(48'h5A1234560000, 24'h000001);
        issue(48'hFA11F0010FFF, 24'hFFFFFF);
        $display("corner cases done");
        for (int k = 0; k < 60; k++) begin
            r0 = $random(seed);
            r1 = $random(seed);
            issue({r0, r1[15:0]}, {r1[31:16], 7'h0, r1[2:0] == 3'h0});
        end
        $display("random traffic done");
        report_and_stop();
    end
endmodule : tb_instr_length_and_address_gen
bind instr_length_and_address_gen instr_decode_props #(.DATA_W(DATA_W))
    instr_decode_props_inst (
    .clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
    .instr_addr(instr_addr), .gr_rd_sel(gr_rd_sel),
    .gr_rd_data(gr_rd_data), .busy(busy), .dec_valid(dec_valid),
    .op_code(op_code), .len_halfwords(len_halfwords),
    .data_type(data_type), .operation(operation), .r1_addr(r1_addr),
    .r2_addr(r2_addr), .op1_in_storage(op1_in_storage),
    .op2_in_storage(op2_in_storage), .addr1(addr1), .addr2(addr2),
    .spec_exc(spec_exc));
